// ===== rtl/spss_seq.sv
// spss_seq: power-state and boot sequencer for one stacked monitor
// assumes pins are asynchronous levels, apb master on CLK, RST_B is
// the power-on reset of the core once the oscillator runs
// Summary of operation
// - wake pin or lower tone leaves shutdown
// - wake pin high cancels commanded power-down
// - power-down bit enters shutdown, wake low
// - silence timer expiry enters shutdown
// - armed digital supply drop enters shutdown
// - either thermal trip enters shutdown, own flag
// - io supply delay or 5v rail drop
// - regulator driving, main supply low too long
// - io supply drop enters shutdown
// - send upward wake tone on each wake
// - lower link only listens during shutdown
// - same boot sequence for every reset
// - oscillator starts after all supplies good
// - start tone then wait 10 us memory
// - load registers, defaults, copy to analog
// - address source zero samples gpio address
// - sample digital temperature, clear masked faults
// - wait analog fault clear or host abort
// - stack link monitored after tone ends
// - reset fault cleared, regulator off if disabled
// - cell faults read zero until sample-all
// - idle after boot, or shutdown
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module spss_seq #(
   parameter int NVM_CYC  = spss_pkg::NVM_CYCLES,
   parameter int TICK_CYC = spss_pkg::TICK_CYCLES
) (
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        RST_B,
   // apb slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // asynchronous pins and analog status
   input  wire logic        WAKE_PIN,
   input  wire logic        LOWER_TONE,
   input  wire logic [4:0]  GPIO_ADDR,
   input  wire logic        MAIN_SUPPLY_OK,
   input  wire logic        DIGITAL_SUPPLY_OK,
   input  wire logic        IO_SUPPLY_OK,
   input  wire logic        IO_SUPPLY_TIMEOUT,
   input  wire logic        ALWAYS_ON_5V_OK,
   input  wire logic        MAIN_SUPPLY_TIMEOUT,
   input  wire logic        THERMAL_TRIP_DIG,
   input  wire logic        THERMAL_TRIP_ANA,
   input  wire logic        ANALOG_SUPPLY_FAULT,
   // link events from the frame logic (same clock)
   input  wire logic        VALID_FRAME,
   input  wire logic        SAMPLE_ALL_DONE,
   input  wire logic        TEMP_SAMPLE_DONE,
   // outputs
   output logic             UPPER_TONE_TX,
   output logic             LOWER_TX_EN,
   output logic             UART_MON_EN,
   output logic             STACK_MON_EN,
   output logic             ANALOG_FAULT_EN,
   output logic             REGULATOR_BASE_DRIVE,
   output logic             ANALOG_COPY,
   output logic             MASKED_FAULT_CLR,
   output logic             TEMP_SAMPLE_REQ,
   output logic             CELL_FAULT_VALID,
   output logic [4:0]       COMM_ADDR,
   output logic             POWER_OFF
);
   localparam int NS = 9;
   spss_tone_if tone_if ();
   logic [NS-1:0] sy;
   logic wake_s;
   logic tone_s;
   logic [4:0] gpio_s;
   logic supp_main;
   logic supp_io;

   spss_sync #(.W(NS)) u_sync (
      .CLK   (CLK),
      .RST_B (RST_B),
      .d     ({WAKE_PIN, LOWER_TONE, IO_SUPPLY_TIMEOUT, ALWAYS_ON_5V_OK,
               MAIN_SUPPLY_TIMEOUT, THERMAL_TRIP_DIG, THERMAL_TRIP_ANA,
               ANALOG_SUPPLY_FAULT, DIGITAL_SUPPLY_OK}),
      .q     (sy)
   );
   spss_sync #(.W(7)) u_sync2 (
      .CLK   (CLK),
      .RST_B (RST_B),
      .d     ({GPIO_ADDR, MAIN_SUPPLY_OK, IO_SUPPLY_OK}),
      .q     ({gpio_s, supp_main, supp_io})
   );
   spss_tone_gen u_tone (
      .CLK   (CLK),
      .RST_B (RST_B),
      .tone  (tone_if.gen)
   );

   assign wake_s = sy[8];
   assign tone_s = sy[7];

   typedef struct packed {
      spss_pkg::spss_state_t st;
      logic [15:0] wait_cnt;
      logic [15:0] tick_cnt;
      logic [15:0] silence;
      logic [15:0] timeout;
      logic [1:0]  cfg;
      logic        cnt_inh;
      logic        dig_arm;
      logic        dig_arm_rd;
      logic        boot;
      logic        reset_flt;
      logic        therm_dig;
      logic        therm_ana;
      logic        reg_off;
      logic        fault_en;
      logic        valid;
      logic        tone_go;
      logic        tone_d;
      logic        tx_en;
      logic [4:0]  addr;
      logic        pwroff;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } spss_seq_t;
   spss_seq_t r;
   spss_seq_t next_r;

   // apb word decode, shared by reads and writes
   function automatic logic is_reg(input logic [7:0] a,
                                   input logic [7:0] o);
      return a == o;
   endfunction

   logic acc;
   logic wr;
   logic shut_req;
   logic tick;
   assign acc  = PSEL && PENABLE && !r.pready;
   assign wr   = acc && PWRITE;
   assign tick = (r.tick_cnt == 16'h0000);

   // any shutdown cause; io supply drop enters shutdown like the rest
   always_comb begin
      shut_req = 1'b0;
      if (wr && is_reg(PADDR, spss_pkg::ADDR_CTRL) &&
          PWDATA[spss_pkg::CTRL_POWER_DOWN_BIT]) shut_req = 1'b1;
      if (r.silence == 16'h0000) shut_req = 1'b1;
      if (r.dig_arm && !sy[0]) shut_req = 1'b1;
      if (sy[3] || sy[2]) shut_req = 1'b1;
      if (sy[6] || !sy[5]) shut_req = 1'b1;
      if (REGULATOR_BASE_DRIVE && sy[4]) shut_req = 1'b1;
      if (!supp_io) shut_req = 1'b1;
   end

   // whole state in one update
   always_comb begin
      next_r = r;
      next_r.tone_go = 1'b0;
      next_r.tone_d  = tone_s; // edge detector, idle low like the pin
      next_r.pready  = acc;
      next_r.pslverr = 1'b0;
      next_r.tick_cnt = tick ? 16'(TICK_CYC - 1) : r.tick_cnt - 16'h0001;
      // silence timer: valid frames reload unless inhibited
      if (VALID_FRAME && !r.cnt_inh) next_r.silence = r.timeout;
      else if (tick && r.silence != 16'h0000)
         next_r.silence = r.silence - 16'h0001;
      // thermal flags sticky, set wins over clear
      if (sy[3]) next_r.therm_dig = 1'b1;
      if (sy[2]) next_r.therm_ana = 1'b1;
      if (SAMPLE_ALL_DONE) next_r.valid = 1'b1;
      if (r.wait_cnt != 16'h0000) next_r.wait_cnt = r.wait_cnt - 16'h0001;
      // register writes
      if (wr) begin
         if (is_reg(PADDR, spss_pkg::ADDR_TEST)) begin
            next_r.cnt_inh = PWDATA[spss_pkg::TEST_CNT_INH];
            next_r.dig_arm_rd = PWDATA[spss_pkg::TEST_DIG_ARM];
            if (PWDATA[spss_pkg::TEST_DIG_ARM]) next_r.dig_arm = 1'b1;
         end else if (is_reg(PADDR, spss_pkg::ADDR_CONFIG)) begin
            next_r.cfg = PWDATA[1:0];
         end else if (is_reg(PADDR, spss_pkg::ADDR_TIMEOUT)) begin
            next_r.timeout = PWDATA[15:0];
            next_r.silence = PWDATA[15:0];
         end else if (is_reg(PADDR, spss_pkg::ADDR_STATUS)) begin
            if (PWDATA[spss_pkg::STS_BOOT] && r.boot)
               next_r.fault_en = 1'b1;
            if (PWDATA[spss_pkg::STS_BOOT]) next_r.boot = 1'b0;
         end else if (is_reg(PADDR, spss_pkg::ADDR_SYSFLT)) begin
            if (PWDATA[spss_pkg::FLT_RESET]) next_r.reset_flt = 1'b0;
            if (PWDATA[spss_pkg::FLT_THERM_DIG] && !sy[3])
               next_r.therm_dig = 1'b0;
            if (PWDATA[spss_pkg::FLT_THERM_ANA] && !sy[2])
               next_r.therm_ana = 1'b0;
         end else if (!is_reg(PADDR, spss_pkg::ADDR_CTRL)) begin
            next_r.pslverr = 1'b1;
         end
      end
      // analog supply fault gone ends the parallel wait
      if (r.boot && !sy[1] && r.st == spss_pkg::ST_TONE_END ||
          r.boot && !sy[1] && r.st == spss_pkg::ST_IDLE) begin
         next_r.fault_en = 1'b1;
         next_r.boot     = 1'b0;
      end
      // external regulator turns off after reset fault is cleared
      if (!r.reset_flt && r.cfg[spss_pkg::CFG_REG_DIS])
         next_r.reg_off = 1'b1;
      // soft reset or a fresh tone from below while awake restarts boot, unless the case or shutdown entry below also sets the state;
      // only the rising edge counts, else the tone that woke us loops
      if (r.st != spss_pkg::ST_SHUTDOWN &&
          (tone_s && !r.tone_d ||
           wr && is_reg(PADDR, spss_pkg::ADDR_CTRL) &&
           PWDATA[spss_pkg::CTRL_SOFT_RST]))
         next_r.st = spss_pkg::ST_POR;
      case (r.st)
         spss_pkg::ST_SHUTDOWN: begin
            next_r.pwroff = 1'b1;
            if (wake_s || tone_s) begin
               next_r.st = spss_pkg::ST_POR;
               next_r.pwroff = 1'b0;
            end
         end
         spss_pkg::ST_POR: begin
            // core supplies must be good before the oscillator runs
            if (supp_main && sy[0] && supp_io && !shut_req) begin
               next_r.tone_go  = 1'b1;
               next_r.wait_cnt = 16'(NVM_CYC - 1);
               next_r.boot     = 1'b1;
               next_r.fault_en = 1'b0;
               next_r.valid    = 1'b0;
               next_r.reset_flt = 1'b1;
               next_r.reg_off  = 1'b0;
               next_r.st = spss_pkg::ST_NVM_WAIT;
            end
         end
         spss_pkg::ST_NVM_WAIT:
            if (r.wait_cnt == 16'h0000) next_r.st = spss_pkg::ST_LOAD;
         spss_pkg::ST_LOAD: begin
            // unstored fields take defaults
            next_r.cfg     = spss_pkg::CFG_RESET;
            next_r.timeout = spss_pkg::TIMEOUT_RESET;
            next_r.silence = spss_pkg::TIMEOUT_RESET;
            next_r.st = spss_pkg::ST_ADDR;
         end
         spss_pkg::ST_ADDR: begin
            if (!r.cfg[spss_pkg::CFG_ADDR_SRC]) next_r.addr = gpio_s;
            next_r.st = spss_pkg::ST_TEMP;
         end
         spss_pkg::ST_TEMP:
            if (TEMP_SAMPLE_DONE) next_r.st = spss_pkg::ST_CLEAR;
         spss_pkg::ST_CLEAR: next_r.st = spss_pkg::ST_UART;
         spss_pkg::ST_UART: next_r.st = spss_pkg::ST_TONE_END;
         spss_pkg::ST_TONE_END:
            if (!tone_if.busy && !r.tone_go)
               next_r.st = spss_pkg::ST_IDLE;
         spss_pkg::ST_IDLE: ;
         default: next_r.st = spss_pkg::ST_SHUTDOWN;
      endcase
      // shutdown entry; wake pin high bounces back to boot
      // not from POR: the supply flops read zero until the synchroniser
      // fills, and POR itself waits for good supplies
      if (shut_req && r.st != spss_pkg::ST_SHUTDOWN &&
          r.st != spss_pkg::ST_POR) begin
         next_r.dig_arm    = 1'b0;
         next_r.dig_arm_rd = 1'b0;
         next_r.st = wake_s ? spss_pkg::ST_POR : spss_pkg::ST_SHUTDOWN;
      end
      // lower link drive follows the state being entered, from a flop
      next_r.tx_en = next_r.st != spss_pkg::ST_SHUTDOWN;
      // read mux
      next_r.prdata = 32'h0000_0000;
      if (acc && !PWRITE) begin
         if (is_reg(PADDR, spss_pkg::ADDR_TEST))
            next_r.prdata = {30'h0, r.dig_arm_rd, r.cnt_inh};
         else if (is_reg(PADDR, spss_pkg::ADDR_CONFIG))
            next_r.prdata = {30'h0, r.cfg};
         else if (is_reg(PADDR, spss_pkg::ADDR_STATUS))
            next_r.prdata = {30'h0, r.boot, r.boot};
         else if (is_reg(PADDR, spss_pkg::ADDR_SYSFLT))
            next_r.prdata = {28'h0, r.valid, r.therm_ana, r.therm_dig,
                             r.reset_flt};
         else if (is_reg(PADDR, spss_pkg::ADDR_TIMEOUT))
            next_r.prdata = {16'h0, r.timeout};
         else if (is_reg(PADDR, spss_pkg::ADDR_STATE))
            next_r.prdata = {17'h0, r.addr, r.st};
         else if (!is_reg(PADDR, spss_pkg::ADDR_CTRL))
            next_r.pslverr = 1'b1;
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         r <= '0;
         r.st      <= spss_pkg::ST_POR;
         r.timeout <= spss_pkg::TIMEOUT_RESET;
         r.silence <= spss_pkg::TIMEOUT_RESET;
      end else begin
         r <= next_r;
      end
   end

   assign tone_if.start = r.tone_go;

   // outputs, flops or decodes of the state and flag flops; the tone is the timer flop
   assign PRDATA  = r.prdata;
   assign PREADY  = r.pready;
   assign PSLVERR = r.pslverr;
   assign UPPER_TONE_TX = tone_if.busy;
   assign LOWER_TX_EN   = r.tx_en;
   assign UART_MON_EN   = r.st == spss_pkg::ST_UART ||
                          r.st == spss_pkg::ST_TONE_END ||
                          r.st == spss_pkg::ST_IDLE;
   assign STACK_MON_EN  = r.st == spss_pkg::ST_IDLE;
   assign ANALOG_FAULT_EN = r.fault_en;
   assign REGULATOR_BASE_DRIVE = !r.pwroff && !r.reg_off;
   assign ANALOG_COPY   = r.st == spss_pkg::ST_ADDR;
   assign MASKED_FAULT_CLR = r.st == spss_pkg::ST_CLEAR;
   assign TEMP_SAMPLE_REQ  = r.st == spss_pkg::ST_TEMP;
   assign CELL_FAULT_VALID = r.valid;
   assign COMM_ADDR = r.addr;
   assign POWER_OFF = r.pwroff;

   // checks
   chk_tone_on_boot: assert property (@(posedge CLK) disable iff (!RST_B)
      r.tone_go |=> tone_if.busy) else $error("tone not started");
   chk_stack_after: assert property (@(posedge CLK) disable iff (!RST_B)
      STACK_MON_EN |-> !tone_if.busy) else $error("stack mon early");
   chk_quiet_sleep: assert property (@(posedge CLK) disable iff (!RST_B)
      r.st == spss_pkg::ST_SHUTDOWN |-> !LOWER_TX_EN)
      else $error("tx in shutdown");
   chk_wake_exit: assert property (@(posedge CLK) disable iff (!RST_B)
      r.st == spss_pkg::ST_SHUTDOWN && (wake_s || tone_s)
      |=> r.st == spss_pkg::ST_POR) else $error("no wake");
   chk_pin_bounce: assert property (@(posedge CLK) disable iff (!RST_B)
      shut_req && wake_s && r.st != spss_pkg::ST_SHUTDOWN
      |=> r.st == spss_pkg::ST_POR) else $error("stayed asleep");
   chk_therm_flag: assert property (@(posedge CLK) disable iff (!RST_B)
      sy[3] |=> r.therm_dig) else $error("thermal flag lost");
   chk_nvm_wait: assert property (@(posedge CLK) disable iff (!RST_B)
      $rose(r.st == spss_pkg::ST_NVM_WAIT) |-> r.wait_cnt ==
      16'(NVM_CYC - 1)) else $error("bad memory wait");
   chk_valid_clr: assert property (@(posedge CLK) disable iff (!RST_B)
      r.st == spss_pkg::ST_NVM_WAIT && $past(r.st) == spss_pkg::ST_POR
      |-> !CELL_FAULT_VALID) else $error("faults valid after reset");
   cov_wake: cover property (@(posedge CLK) disable iff (!RST_B)
      r.st == spss_pkg::ST_SHUTDOWN ##1 r.st == spss_pkg::ST_POR);
   cov_idle: cover property (@(posedge CLK) disable iff (!RST_B)
      r.st == spss_pkg::ST_TONE_END ##1 r.st == spss_pkg::ST_IDLE);
   cov_abort: cover property (@(posedge CLK) disable iff (!RST_B)
      r.boot ##1 !r.boot && r.fault_en);
endmodule // spss_seq

// ===== rtl/spss_pkg.sv
// spss_pkg: shared constants for the stack power-state sequencer
// assumes a 100 MHz core clock and a 32-bit apb register bus
package spss_pkg;
   // register byte offsets
   localparam logic [7:0] ADDR_CTRL   = 8'h00; // device_control_reg
   localparam logic [7:0] ADDR_TEST   = 8'h04; // test_config_reg
   localparam logic [7:0] ADDR_CONFIG = 8'h08; // device_config_reg
   localparam logic [7:0] ADDR_STATUS = 8'h0C; // boot_in_progress etc
   localparam logic [7:0] ADDR_SYSFLT = 8'h10; // system_fault_reg
   localparam logic [7:0] ADDR_TIMEOUT = 8'h14; // comm_timeout_reg
   localparam logic [7:0] ADDR_STATE  = 8'h18; // state and address
   // field positions
   localparam int CTRL_POWER_DOWN_BIT      = 0;
   localparam int CTRL_SOFT_RST   = 1;
   localparam int TEST_CNT_INH    = 0;
   localparam int TEST_DIG_ARM    = 1;
   localparam int CFG_ADDR_SRC    = 0;
   localparam int CFG_REG_DIS     = 1;
   localparam int STS_BOOT        = 0;
   localparam int STS_UNRELIABLE  = 1;
   localparam int FLT_RESET       = 0;
   localparam int FLT_THERM_DIG   = 1;
   localparam int FLT_THERM_ANA   = 2;
   localparam int FLT_SAMPLE_OK   = 3;
   localparam logic [1:0] CFG_RESET = 2'h0;
   localparam logic [15:0] TIMEOUT_RESET = 16'hFFFF;
   // timing
   localparam int CLK_MHZ      = 100;
   localparam int NVM_WAIT_NS  = 10000;
   localparam int NVM_CYCLES   = (NVM_WAIT_NS * CLK_MHZ + 999) / 1000;
   localparam int TONE_NS      = 2000;
   localparam int TONE_CYCLES  = (TONE_NS * CLK_MHZ) / 1000;
   localparam int TICK_US      = 250; // timeout counter tick, 4 kHz
   localparam int TICK_CYCLES  = TICK_US * CLK_MHZ;
   // boot and power states, one-hot
   typedef enum logic [9:0] {
      ST_SHUTDOWN = 10'h001,
      ST_POR      = 10'h002,
      ST_NVM_WAIT = 10'h004,
      ST_LOAD     = 10'h008,
      ST_ADDR     = 10'h010,
      ST_TEMP     = 10'h020,
      ST_CLEAR    = 10'h040,
      ST_UART     = 10'h080,
      ST_TONE_END = 10'h100,
      ST_IDLE     = 10'h200
   } spss_state_t;
endpackage

// ===== rtl/spss_tone_if.sv
// spss_tone_if: start/busy handshake between sequencer and tone timer
// assumes both ends on the same core clock
`timescale 1ns/1ps
interface spss_tone_if;
   logic start;
   logic busy;
   modport ctrl (output start, input  busy);
   modport gen  (input  start, output busy);
endinterface

// ===== rtl/spss_tone_gen.sv
// spss_tone_gen: times the upward wake tone burst
// assumes start is a one-cycle pulse from the sequencer
`timescale 1ns/1ps
module spss_tone_gen #(
   parameter int LEN = spss_pkg::TONE_CYCLES
) (
   // clock and reset
   input  wire logic CLK,
   input  wire logic RST_B,
   // handshake
   spss_tone_if.gen  tone
);
   typedef struct packed {
      logic [15:0] cnt;
      logic        busy;
   } spss_tone_t;
   spss_tone_t r;
   spss_tone_t next_r;

   // restart on every start so back to back wakes lengthen the tone
   always_comb begin
      next_r = r;
      if (tone.start) begin
         next_r.busy = 1'b1;
         next_r.cnt  = 16'(LEN - 1);
      end else if (r.busy) begin
         if (r.cnt == 16'h0000) next_r.busy = 1'b0;
         else next_r.cnt = r.cnt - 16'h0001;
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) r <= '0;
      else r <= next_r;
   end
   assign tone.busy = r.busy;
endmodule // spss_tone_gen

// ===== rtl/spss_sync.sv
// spss_sync: two-flop synchroniser bank for asynchronous pins
// assumes inputs are quasi-static levels
`timescale 1ns/1ps
module spss_sync #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic         CLK,
   input  wire logic         RST_B,
   // levels
   input  wire logic [W-1:0] d,
   output logic [W-1:0]      q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } spss_sync_t;
   spss_sync_t r;
   spss_sync_t next_r;

   // first stage feeds only the second stage
   always_comb begin
      next_r.s1 = d;
      next_r.s2 = r.s1;
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) r <= '0;
      else r <= next_r;
   end
   assign q = r.s2;
endmodule // spss_sync

// ===== dv/spss_far_model.sv
// spss_far_model: host wake driver plus the neighbours below and above
// assumes the bench raises wake_req or tone_req as levels on CLK
`timescale 1ns/1ps
module spss_far_model (
   // clock
   input  wire logic CLK,
   // requests from the bench
   input  wire logic wake_req,
   input  wire logic tone_req,
   // device pins
   input  wire logic UPPER_TONE_TX,
   output logic      WAKE_PIN,
   output logic      LOWER_TONE,
   // length of the last upward tone
   output int        tone_len
);
   int run = 0;
   initial begin
      WAKE_PIN = 1'b0;
      LOWER_TONE = 1'b0;
      tone_len = 0;
   end
   // wake pin always driven, low unless asked, so it never floats
   always @(posedge CLK) WAKE_PIN <= wake_req;
   // tone burst from the device below, held while requested
   always @(posedge CLK) LOWER_TONE <= tone_req;
   // device above times the upward tone; lands a cycle after its end
   always @(posedge CLK) begin
      if (UPPER_TONE_TX) run <= run + 1;
      else if (run != 0) begin
         tone_len <= run;
         run <= 0;
      end
   end
endmodule // spss_far_model

// ===== dv/stack_power_state_sequencer_tb.sv
// stack_power_state_sequencer_tb: random and corner tests of spss_seq
// assumes 100 MHz CLK, short memory wait and tick via parameters
`timescale 1ns/1ps
`define CHK(nm, ex, sn) \
   begin \
      cmp_count++; \
      if ((sn) !== (ex)) begin \
         n_errors++; \
         $display("CHECK FAILED %s exp %0h seen %0h", nm, ex, sn); \
      end \
   end
module stack_power_state_sequencer_tb;
   logic        CLK = 1'b0;
   logic        RST_B = 1'b0;
   logic        PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
   logic [7:0]  PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0, PRDATA, rdat;
   logic        PREADY, PSLVERR, serr, WAKE_PIN, LOWER_TONE;
   logic [4:0]  GPIO_ADDR = 5'h00, COMM_ADDR;
   logic [6:0]  bad = 7'h00;
   logic        ANALOG_SUPPLY_FAULT = 1'b1, VALID_FRAME = 1'b0;
   logic        SAMPLE_ALL_DONE = 1'b0, TEMP_SAMPLE_DONE = 1'b0;
   logic        wake_req = 1'b0, tone_req = 1'b0, main_low = 1'b0;
   logic        UPPER_TONE_TX, LOWER_TX_EN, UART_MON_EN, STACK_MON_EN;
   logic        ANALOG_FAULT_EN, REGULATOR_BASE_DRIVE, ANALOG_COPY;
   logic        MASKED_FAULT_CLR, TEMP_SAMPLE_REQ, CELL_FAULT_VALID;
   logic        POWER_OFF;
   int          n_errors = 0, cmp_count = 0, tone_len, n_clr = 0, t, k;
   // one fault source per bit, swept by the shutdown test
   wire MAIN_SUPPLY_OK      = ~main_low;
   wire IO_SUPPLY_OK        = ~bad[0];
   wire IO_SUPPLY_TIMEOUT   = bad[1];
   wire ALWAYS_ON_5V_OK     = ~bad[2];
   wire MAIN_SUPPLY_TIMEOUT = bad[3];
   wire THERMAL_TRIP_DIG    = bad[4];
   wire THERMAL_TRIP_ANA    = bad[5];
   wire DIGITAL_SUPPLY_OK   = ~bad[6];

   spss_seq #(.NVM_CYC(4), .TICK_CYC(2)) uut (.*);
   spss_far_model far (.CLK(CLK), .wake_req(wake_req),
      .tone_req(tone_req), .UPPER_TONE_TX(UPPER_TONE_TX),
      .WAKE_PIN(WAKE_PIN), .LOWER_TONE(LOWER_TONE), .tone_len(tone_len));

   initial forever #5 CLK = ~CLK;
   // frame logic stand-in: answers a temperature request next cycle
   always @(posedge CLK) begin
      TEMP_SAMPLE_DONE <= TEMP_SAMPLE_REQ && !TEMP_SAMPLE_DONE;
      if (MASKED_FAULT_CLR === 1'b1 && ANALOG_COPY !== 1'bx) n_clr++;
   end

   // apb master: holds the request until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      // only the watchdog ends a wait for the slave
      do begin
         @(posedge CLK);
      end while (PREADY !== 1'b1);
      rdat = PRDATA;
      serr = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask

   task automatic boot();
      int n;
      for (n = 0; n < 3000 && STACK_MON_EN !== 1'b1; n++) @(posedge CLK);
      `CHK("stack_mon", 1'b1, STACK_MON_EN)
      `CHK("tone_busy", 1'b0, UPPER_TONE_TX)
      repeat (2) @(posedge CLK);
      `CHK("tone_len", spss_pkg::TONE_CYCLES, tone_len)
   endtask

   task automatic sleep_chk();
      int n;
      for (n = 0; n < 20 && POWER_OFF !== 1'b1; n++) @(posedge CLK);
      `CHK("power_off", 1'b1, POWER_OFF)
      `CHK("lower_tx", 1'b0, LOWER_TX_EN)
   endtask

   // wake by pin or by tone; release only once the device is up
   task automatic wake(input logic by_tone);
      int n;
      if (by_tone) tone_req <= 1'b1;
      else wake_req <= 1'b1;
      for (n = 0; n < 100 && POWER_OFF !== 1'b0; n++) @(posedge CLK);
      `CHK("woke", 1'b0, POWER_OFF)
      tone_req <= 1'b0;
      wake_req <= 1'b0;
      boot();
   endtask

   task automatic stop_test();
      $display("counts: %0d compares, %0d mismatches", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // watchdog: whole run needs well under 10000 cycles
   initial begin
      #400us;
      n_errors++;
      stop_test();
   end

   initial begin
      t = $urandom(32'h33F19155);
      repeat (5) @(posedge CLK);
      GPIO_ADDR <= 5'($urandom);
      RST_B <= 1'b1;
      // boot, address, status and abort of the analog wait
      boot();
      `CHK("addr", GPIO_ADDR, COMM_ADDR)
      `CHK("clears", 1'b1, n_clr > 0)
      apb(1'b0, spss_pkg::ADDR_STATE, 32'h0);
      `CHK("state", spss_pkg::ST_IDLE, rdat[9:0])
      apb(1'b0, spss_pkg::ADDR_STATUS, 32'h0);
      `CHK("boot_sts", 2'h3, rdat[1:0])
      `CHK("afe_en0", 1'b0, ANALOG_FAULT_EN)
      apb(1'b1, spss_pkg::ADDR_STATUS, 32'h1);
      repeat (3) @(posedge CLK);
      `CHK("afe_en1", 1'b1, ANALOG_FAULT_EN)
      apb(1'b0, spss_pkg::ADDR_STATUS, 32'h0);
      `CHK("boot_clr", 1'b0, rdat[spss_pkg::STS_BOOT])
      `CHK("cell_v0", 1'b0, CELL_FAULT_VALID)
      SAMPLE_ALL_DONE <= 1'b1;
      @(posedge CLK);
      SAMPLE_ALL_DONE <= 1'b0;
      repeat (2) @(posedge CLK);
      `CHK("cell_v1", 1'b1, CELL_FAULT_VALID)
      apb(1'b0, 8'hFC, 32'h0);
      `CHK("unmapped", 1'b1, serr)
      $display("test boot done");
      // commanded power-down, then with the wake pin still high
      apb(1'b1, spss_pkg::ADDR_CTRL, 32'h1);
      sleep_chk();
      wake(1'b0);
      wake_req <= 1'b1;
      repeat (8) @(posedge CLK);
      apb(1'b1, spss_pkg::ADDR_CTRL, 32'h1);
      // even one cycle asleep would drop the lower link drive
      t = int'(LOWER_TX_EN === 1'b1);
      for (k = 0; k < 60; k++) begin
         @(posedge CLK);
         if (LOWER_TX_EN !== 1'b1) t = 0;
      end
      `CHK("stays_up", 1'b0, POWER_OFF)
      `CHK("no_sleep", 1'b1, t[0])
      wake_req <= 1'b0;
      boot();
      $display("test power-down done");
      // every fault-pin shutdown source; digital supply only once armed
      for (k = 0; k < 7; k++) begin
         if (k == 6) begin
            apb(1'b1, spss_pkg::ADDR_TEST, 32'h2);
            apb(1'b1, spss_pkg::ADDR_TEST, 32'h0);
            apb(1'b0, spss_pkg::ADDR_TEST, 32'h0);
            `CHK("arm_rd", 1'b0, rdat[spss_pkg::TEST_DIG_ARM])
         end
         bad <= 7'h01 << k;
         sleep_chk();
         if (k == 4 || k == 5) begin
            apb(1'b0, spss_pkg::ADDR_SYSFLT, 32'h0);
            `CHK("therm", 1'b1, rdat[k - 3])
         end
         bad <= 7'h00;
         wake(k[0]);
      end
      $display("test shutdown sources done");
      // reset fault cleared with regulator disabled
      apb(1'b1, spss_pkg::ADDR_CONFIG, 32'h2);
      `CHK("reg_on", 1'b1, REGULATOR_BASE_DRIVE)
      apb(1'b1, spss_pkg::ADDR_SYSFLT, 32'h1);
      repeat (3) @(posedge CLK);
      `CHK("reg_off", 1'b0, REGULATOR_BASE_DRIVE)
      $display("test regulator done");
      // soft reset with main supply low: boot must wait for it
      main_low <= 1'b1;
      apb(1'b1, spss_pkg::ADDR_CTRL, 32'h2);
      `CHK("soft_rst", 1'b0, STACK_MON_EN)
      repeat (20) @(posedge CLK);
      `CHK("osc_wait", 1'b0, UPPER_TONE_TX)
      main_low <= 1'b0;
      boot();
      // analog supply fault going away ends the wait by itself
      ANALOG_SUPPLY_FAULT <= 1'b0;
      repeat (5) @(posedge CLK);
      `CHK("afe_auto", 1'b1, ANALOG_FAULT_EN)
      $display("test soft reset done");
      // silence timer with counter reset inhibited and frames arriving
      t = 2 + ($urandom % 4);
      VALID_FRAME <= 1'b1;
      apb(1'b1, spss_pkg::ADDR_TIMEOUT, 32'(t));
      repeat (40) @(posedge CLK);
      `CHK("frames_keep", 1'b0, POWER_OFF)
      apb(1'b1, spss_pkg::ADDR_TEST, 32'h1);
      for (k = 0; k < 200 && POWER_OFF !== 1'b1; k++) begin
         @(posedge CLK);
         VALID_FRAME <= k[0];
      end
      VALID_FRAME <= 1'b0;
      `CHK("timeout", 1'b1, POWER_OFF)
      $display("test timeout done");
      stop_test();
   end
endmodule // stack_power_state_sequencer_tb
